// file: include/lane_mask_pkg.sv
// Package for the byte-lane write masking block
package lane_mask_pkg;
  localparam int LANE_BITS = 9;
  localparam int LANES_WIDE = 4;
  localparam int LANES_NARROW = 2;
  localparam int ADDR_BITS_DEFAULT = 8;
  localparam logic [0:0] ADDR_STEP = 1'h1;
  localparam int CLK_PERIOD_NS = 40;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_WORD0 = 4'h4,
    ST_WORD1 = 4'h8
  } wr_state_e;
  typedef struct packed {
    logic command_load_n;
    logic read_write;
  } cmd_s;
endpackage : lane_mask_pkg

// file: logic/lane_merge.sv
// Per-lane write enable and merge of one masked word
`timescale 1ns/100ps
module lane_merge #(
  parameter int LANES = 2,
  parameter int LANE_BITS = 9
) (
  input wire logic [LANES*LANE_BITS-1:0] old_word,
  input wire logic [LANES*LANE_BITS-1:0] new_word,
  input wire logic [LANES-1:0] lane_write_select_n,
  output logic [LANES*LANE_BITS-1:0] merged_word,
  output logic [LANES-1:0] lane_we
);
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      // [RQ1] Low select writes lane
      assign lane_we[g] = ~lane_write_select_n[g];
      // [RQ13] Unselected lanes keep cells
      assign merged_word[g*LANE_BITS +: LANE_BITS] = lane_we[g] ?
        new_word[g*LANE_BITS +: LANE_BITS] : old_word[g*LANE_BITS +: LANE_BITS];
    end
  endgenerate
endmodule : lane_merge

// file: logic/sram_byte_write_mask.sv
// Write path with byte-lane masking for a two-word burst DDR SRAM core
// Summary of operation
// [RQ1] 18-bit: select 0 covers bits 8:0, select 1 bits 17:9; low writes.
// [RQ2] 18-bit: both selects high means nothing from that word is written.
// [RQ3] 36-bit: four selects cover 8:0, 17:9, 26:18, 35:27; unselected lanes kept.
// [RQ4] 36-bit: all selects high leaves the location untouched for that word.
// [RQ5] Selects sampled separately with each word; each word may differ.
// [RQ6] After power-up deselected, data outputs high impedance until a command.
// [RQ7] First word goes to latched address, second to address plus one.
// [RQ8] Data captured on both clock rises; output data launched on both.
// [RQ9] Timing counts from start cycle t; words placed at t+1.
// [RQ10] Controller should park positive clock high when stopped.
// [RQ11] Controller starts write with load and read-write low, then two words.
// [RQ12] Load high at positive rise is a no-operation.
// [RQ13] Words merge as per-lane write enables into the array.
`timescale 1ns/100ps
module sram_byte_write_mask #(
  parameter int LANES = lane_mask_pkg::LANES_NARROW,
  parameter int ADDR_BITS = lane_mask_pkg::ADDR_BITS_DEFAULT
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_pos,
  input wire logic command_load_n,
  input wire logic read_write,
  input wire logic [ADDR_BITS-1:0] addr,
  input wire logic [LANES*lane_mask_pkg::LANE_BITS-1:0] data_in,
  input wire logic [LANES-1:0] lane_write_select_n,
  output logic [LANES*lane_mask_pkg::LANE_BITS-1:0] data_out,
  output logic data_out_en,
  output logic write_busy
);
  localparam int W = LANES * lane_mask_pkg::LANE_BITS;
  localparam int DEPTH = 1 << ADDR_BITS;

  // Two-flop synchronisers on all pins but reset_n; clk_pos has a third flop for edge detection
  logic clk_pos_s1_reg, clk_pos_s2_reg, clk_pos_s3_reg;
  lane_mask_pkg::cmd_s cmd_s1_reg, cmd_s2_reg;
  logic [ADDR_BITS-1:0] addr_s1_reg, addr_s2_reg;
  logic [W-1:0] data_s1_reg, data_s2_reg;
  logic [LANES-1:0] sel_s1_reg, sel_s2_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_pos_s1_reg <= 1'h1;
      clk_pos_s2_reg <= 1'h1;
      clk_pos_s3_reg <= 1'h1;
      cmd_s1_reg <= '1;
      cmd_s2_reg <= '1;
      addr_s1_reg <= '0;
      addr_s2_reg <= '0;
      data_s1_reg <= '0;
      data_s2_reg <= '0;
      sel_s1_reg <= '1;
      sel_s2_reg <= '1;
    end else begin
      clk_pos_s1_reg <= clk_pos;
      clk_pos_s2_reg <= clk_pos_s1_reg;
      clk_pos_s3_reg <= clk_pos_s2_reg;
      cmd_s1_reg <= '{command_load_n: command_load_n, read_write: read_write};
      cmd_s2_reg <= cmd_s1_reg;
      addr_s1_reg <= addr;
      addr_s2_reg <= addr_s1_reg;
      data_s1_reg <= data_in;
      data_s2_reg <= data_s1_reg;
      sel_s1_reg <= lane_write_select_n;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  // [RQ8] Rise of either clock phase
  wire pos_rise = clk_pos_s2_reg & ~clk_pos_s3_reg;
  wire inv_rise = ~clk_pos_s2_reg & clk_pos_s3_reg;

  lane_mask_pkg::wr_state_e state_reg, state_next;
  logic [ADDR_BITS-1:0] base_addr_reg;
  logic [W-1:0] mem [DEPTH];

  // [RQ12] Load high starts nothing
  wire start_write = pos_rise & ~cmd_s2_reg.command_load_n & ~cmd_s2_reg.read_write;
  wire start_read = pos_rise & ~cmd_s2_reg.command_load_n & cmd_s2_reg.read_write;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      lane_mask_pkg::ST_IDLE: begin
        if (start_write) begin
          state_next = lane_mask_pkg::ST_WAIT;
        end
      end
      lane_mask_pkg::ST_WAIT: begin
        // [RQ9] Wait for rise t+1
        if (pos_rise) begin
          state_next = lane_mask_pkg::ST_WORD0;
        end
      end
      lane_mask_pkg::ST_WORD0: begin
        if (inv_rise) begin
          state_next = lane_mask_pkg::ST_WORD1;
        end
      end
      lane_mask_pkg::ST_WORD1: begin
        state_next = start_write ? lane_mask_pkg::ST_WAIT : lane_mask_pkg::ST_IDLE;
      end
      default: state_next = lane_mask_pkg::ST_IDLE;
    endcase
  end

  // Word 0 is taken on the same positive rise that enters WORD0
  wire wr_word0 = (state_reg == lane_mask_pkg::ST_WAIT) & pos_rise;
  wire wr_word1 = (state_reg == lane_mask_pkg::ST_WORD0) & inv_rise;
  wire wr_any = wr_word0 | wr_word1;
  // [RQ7] Second word at address plus one
  wire [ADDR_BITS-1:0] wr_addr = wr_word1 ?
    base_addr_reg + ADDR_BITS'(lane_mask_pkg::ADDR_STEP) : base_addr_reg;

  wire [W-1:0] merged;
  wire [LANES-1:0] lane_we;
  // [RQ5] Fresh mask per word
  lane_merge #(
    .LANES(LANES),
    .LANE_BITS(lane_mask_pkg::LANE_BITS)
  ) u_merge (
    .old_word(mem[wr_addr]),
    .new_word(data_s2_reg),
    .lane_write_select_n(sel_s2_reg),
    .merged_word(merged),
    .lane_we(lane_we)
  );

  // [RQ2] [RQ4] All selects high skips the write
  wire do_write = wr_any & (|lane_we);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= lane_mask_pkg::ST_IDLE;
      base_addr_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (start_write) begin
        base_addr_reg <= addr_s2_reg;
      end
    end
  end

  // [RQ3] [RQ13] Lane-merged store
  always_ff @(posedge core_clk) begin
    if (do_write) begin
      mem[wr_addr] <= merged;
    end
  end

  // Read launch kept minimal; it drives data_out with the stored pair and gives the output enable a meaning
  typedef enum logic [3:0] {
    RD_IDLE = 4'h1,
    RD_WAIT = 4'h2,
    RD_WORD0 = 4'h4,
    RD_WORD1 = 4'h8
  } rd_state_e;
  rd_state_e rd_state_reg, rd_state_next;
  logic [ADDR_BITS-1:0] rd_addr_reg;

  // Reads mid-burst are dropped so the launched pair never tears
  wire rd_take = start_read & ((rd_state_reg == RD_IDLE) | (rd_state_reg == RD_WORD1));
  wire launch_word0 = (rd_state_reg == RD_WAIT) & pos_rise;
  wire launch_word1 = (rd_state_reg == RD_WORD0) & inv_rise;
  wire [ADDR_BITS-1:0] rd_addr_second =
    rd_addr_reg + ADDR_BITS'(lane_mask_pkg::ADDR_STEP);
  wire [W-1:0] rd_word0 = mem[rd_addr_reg];
  wire [W-1:0] rd_word1 = mem[rd_addr_second];

  always_comb begin
    rd_state_next = rd_state_reg;
    unique case (rd_state_reg)
      RD_IDLE: begin
        if (rd_take) begin
          rd_state_next = RD_WAIT;
        end
      end
      RD_WAIT: begin
        if (pos_rise) begin
          rd_state_next = RD_WORD0;
        end
      end
      RD_WORD0: begin
        if (inv_rise) begin
          rd_state_next = RD_WORD1;
        end
      end
      RD_WORD1: begin
        if (rd_take) begin
          rd_state_next = RD_WAIT;
        end else if (pos_rise) begin
          rd_state_next = RD_IDLE;
        end
      end
      default: rd_state_next = RD_IDLE;
    endcase
  end

  // Output enable follows the launch states
  wire rd_drive = (rd_state_next == RD_WORD0) | (rd_state_next == RD_WORD1);

  // [RQ6] Deselected and tri-stated from reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_state_reg <= RD_IDLE;
      rd_addr_reg <= '0;
      data_out <= '0;
      data_out_en <= 1'h0;
    end else begin
      rd_state_reg <= rd_state_next;
      data_out_en <= rd_drive;
      if (rd_take) begin
        rd_addr_reg <= addr_s2_reg;
      end
      // [RQ8] Launch on both rises
      if (launch_word0) begin
        data_out <= rd_word0;
      end else if (launch_word1) begin
        data_out <= rd_word1;
      end
    end
  end

  assign write_busy = (state_reg != lane_mask_pkg::ST_IDLE);
endmodule : sram_byte_write_mask

// file: tb/mask_monitor.sv
// Port checks for the write path
`timescale 1ns/100ps
module mask_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_pos,
  input wire logic command_load_n,
  input wire logic read_write,
  input wire logic data_out_en,
  input wire logic write_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_wr; $rose(write_busy); endsequence
  sequence s_rd; $rose(data_out_en); endsequence
  property p_rst; $rose(reset_n) |-> !data_out_en && !write_busy; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_clk; s_wr |-> $past(clk_pos, 2); endproperty
  a_clk: assert property (p_clk) else $error("clk");
  property p_ld; s_wr |-> !$past(command_load_n, 2); endproperty
  a_ld: assert property (p_ld) else $error("ld");
  property p_rw; s_wr |-> !$past(read_write, 2); endproperty
  a_rw: assert property (p_rw) else $error("rw");
  property p_wend; s_wr |-> ##[1:40] !write_busy; endproperty
  a_wend: assert property (p_wend) else $error("wend");
  property p_rend; s_rd |-> ##[1:40] !data_out_en; endproperty
  a_rend: assert property (p_rend) else $error("rend");
  property p_quiet; write_busy |-> !data_out_en; endproperty
  a_quiet: assert property (p_quiet) else $error("quiet");
  property p_ren; s_rd |-> read_write; endproperty
  a_ren: assert property (p_ren) else $error("ren");
endmodule : mask_monitor

// file: tb/ctrl_model.sv
// Controller model: pin clock, command, burst words
`timescale 1ns/100ps
module ctrl_model #(parameter int L = 2, parameter int QW = L * 9) (
  input wire logic core_clk,
  output logic ck,
  output logic ld_n,
  output logic rw,
  output logic [7:0] a,
  output logic [L*9-1:0] d,
  output logic [L-1:0] m_n,
  input wire logic [QW-1:0] q
);
  localparam int W = L * 9;
  int hold = 5;
  initial {ck, ld_n, rw, a, d, m_n} = '1;
  // Each level held long enough for the pin synchroniser
  task automatic half(input logic lvl);
    @(negedge core_clk) ck = lvl;
    repeat (hold) @(negedge core_clk);
  endtask : half
  task automatic burst(input logic r, input logic [7:0] x, input logic [2*W-1:0] v,
    input logic [2*L-1:0] s, output logic [2*QW-1:0] o);
    half(1'h0);
    {ld_n, rw, a} = {1'h0, r, x};
    half(1'h1);
    {ld_n, a, d, m_n} = {1'h1, ~x, v[W-1:0], s[L-1:0]};
    half(1'h0);
    half(1'h1);
    o[QW-1:0] = q;
    {d, m_n} = {v[2*W-1:W], s[2*L-1:L]};
    half(1'h0);
    o[2*QW-1:QW] = q;
    {d, m_n} = ~{d, m_n};
    half(1'h1);
  endtask : burst
endmodule : ctrl_model

// file: tb/testbench.sv
// Bench: masked bursts against a shadow array
`timescale 1ns/100ps
module testbench;
  localparam int L = lane_mask_pkg::LANES_WIDE;
  localparam int W = L * 9;
  localparam int DW = 2 * W;
  localparam int LN = lane_mask_pkg::LANES_NARROW;
  localparam int WN = LN * 9;
  localparam int QW = W + WN;
  logic core_clk, reset_n, ck, ld_n, rw, en, busy, en_n, busy_n;
  logic [7:0] a, x;
  logic [W-1:0] d, q;
  logic [WN-1:0] qn;
  logic [L-1:0] m_n;
  logic [W-1:0] mem [256];
  logic [2*QW-1:0] qq;
  int fail_count = 0;
  int check_count = 0;
  sram_byte_write_mask #(.LANES(L), .ADDR_BITS(8)) dut_u (.core_clk, .reset_n,
    .clk_pos(ck), .command_load_n(ld_n), .read_write(rw), .addr(a), .data_in(d),
    .lane_write_select_n(m_n), .data_out(q), .data_out_en(en), .write_busy(busy));
  // Narrow width shares the bus; its lanes are the low ones of the wide shadow
  sram_byte_write_mask #(.LANES(LN), .ADDR_BITS(8)) dut_narrow_u (.core_clk, .reset_n,
    .clk_pos(ck), .command_load_n(ld_n), .read_write(rw), .addr(a), .data_in(d[WN-1:0]),
    .lane_write_select_n(m_n[LN-1:0]), .data_out(qn), .data_out_en(en_n),
    .write_busy(busy_n));
  ctrl_model #(.L(L), .QW(QW)) ctrl_u (.core_clk, .ck, .ld_n, .rw, .a, .d, .m_n, .q({qn, q}));
  function automatic logic [W-1:0] merge(input logic [W-1:0] o, n, input logic [L-1:0] s);
    for (int g = 0; g < L; g++) if (!s[g]) o[g*9+:9] = n[g*9+:9];
    return o;
  endfunction : merge
  task automatic check(input string nm, input logic [DW-1:0] e, g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : check
  task automatic wr(input logic [7:0] y, input logic [DW-1:0] v, input logic [2*L-1:0] s);
    ctrl_u.burst(1'h0, y, v, s, qq);
    mem[y] = merge(mem[y], v[W-1:0], s[L-1:0]);
    mem[y+8'h1] = merge(mem[y+8'h1], v[DW-1:W], s[2*L-1:L]);
  endtask : wr
  task automatic rd(input logic [7:0] y);
    ctrl_u.burst(1'h1, y, '0, '1, qq);
    check("rd_wide", {mem[y+8'h1], mem[y]}, {qq[QW+W-1:QW], qq[W-1:0]});
    check("rd_narrow", DW'({mem[y+8'h1][WN-1:0], mem[y][WN-1:0]}),
      DW'({qq[2*QW-1:QW+W], qq[QW-1:W]}));
  endtask : rd
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    core_clk = 1'h0;
    forever #(lane_mask_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  end
  initial begin
    #(lane_mask_pkg::CLK_PERIOD_NS * 6000);
    fail_count++;
    stop_test();
  end
  initial begin
    reset_n = 1'h0;
    void'($urandom(32'hcff611f6));
    repeat (2) @(negedge core_clk);
    reset_n = 1'h1;
    for (int i = 0; i < 9; i++) wr(8'(i), DW'({$urandom, $urandom, $urandom}), '0);
    wr(8'hff, DW'({$urandom, $urandom, $urandom}), '0);
    for (int i = 0; i <= L; i++) begin
      wr(8'hff, DW'({$urandom, $urandom}), {L'(~(1 << (L - i))), L'(~(1 << i))});
      rd(8'hff);
    end
    // Slower pin clock for the random mix
    ctrl_u.hold = 9;
    repeat (16) begin
      x = 8'($urandom_range(7));
      wr(x, DW'({$urandom, $urandom, $urandom}), (2*L)'($urandom));
      rd(x);
    end
    stop_test();
  end
endmodule : testbench
bind sram_byte_write_mask mask_monitor mon_u (.core_clk, .reset_n, .clk_pos,
  .command_load_n, .read_write, .data_out_en, .write_busy);
